// ### src/lpm_ctrl.sv
// low-power mode controller: wait/stop sequencing and peripheral gating
//
// Operation
// R1: wait stops cpu clock, bus runs
// R2: stop halts cpu; bus too unless oscillator
// R3: wait clears interrupt mask; reset sets it
// R4: stop clears interrupt mask; reset sets it
// R5: cpu clock held until stabilization elapses
// R6: converter runs in wait, may wake
// R7: stop aborts conversion, resumes after exit
// R8: break active in wait, sets flag
// R9: no oscillator in stop: cgm outputs low
// R10: oscillator in stop: only pll off
// R11: watchdog counts in wait, resets on timeout
// R12: stop cuts watchdog clock, clears prescaler
// R13: stop ignored unless stop enable set
// R14: external irq wakes when unmasked
// R15: keyboard irq wakes when unmasked
// R16: voltage monitor resets out of modes
// R17: serial port runs wait, halts stop
// R18: spi halts in stop, reset aborts
// R19: timers run in wait, freeze in stop
// R20: timebase runs stop only with oscillator
// R21: can active in wait, blocked access
// R22: recovery counter 4096 or 32 cycles
// R23: wake requests synchronized before clock enable
`timescale 1ns/10ps
module lpm_ctrl (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wait_instr,
   input wire logic stop_instr,
   input wire logic ref_clock_tick,
   input wire lpm_pkg::lpm_wake_s wake_req,
   output logic interrupt_mask_flag,
   output logic break_wait_flag,
   output logic device_reset,
   output lpm_pkg::lpm_ctl_s ctl,
   output logic osc_ref_clock_en,
   output logic main_clock_out_en,
   output logic clockgen_irq_out_en,
   output logic watchdog_clock
);

   typedef struct packed {
      lpm_pkg::lpm_mode_e mode;
      logic [lpm_pkg::CFG_WIDTH-1:0] cfg;
      logic [11:0] recover_cnt;
      lpm_pkg::lpm_wake_s sync1;
      lpm_pkg::lpm_wake_s sync2;
      logic imask;
      logic brk_flag;
      logic wd_prescaler_clr;
      logic reset_req;
      logic wd_div;
      logic [31:0] rdata;
   } lpm_state_s;

   lpm_state_s st;
   lpm_state_s next_st;
   logic wr_access;
   logic rd_access;
   logic mapped;
   logic wake_unmasked_wait;
   logic wake_ext_stop;
   logic reset_cause;
   logic stop_allowed;
   logic osc_keep;
   logic bus_keep;
   lpm_pkg::lpm_wake_s w;

   assign w = st.sync2;
   assign wr_access = psel && penable && pwrite;
   assign rd_access = psel && !penable && !pwrite;
   assign mapped = (paddr == lpm_pkg::ADDR_CTRL)
      || (paddr == lpm_pkg::ADDR_CFG) || (paddr == lpm_pkg::ADDR_STATUS);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = st.rdata;

   assign osc_keep = st.cfg[lpm_pkg::CFG_OSC_RUN_IN_STOP];
   assign bus_keep = st.cfg[lpm_pkg::CFG_STOP_OSC_ENABLE];
   assign stop_allowed = st.cfg[lpm_pkg::CFG_STOP_ENABLE]; // R13

   // resets: watchdog in run and wait only, voltage monitor in any mode
   always_comb begin
      reset_cause = w.lvi_trip && st.cfg[lpm_pkg::CFG_LVI_ENABLE]
         && st.cfg[lpm_pkg::CFG_LVI_RESET_ENABLE]; // R16
      if (st.mode != lpm_pkg::LPM_STOP && st.mode != lpm_pkg::LPM_RECOVER
            && w.wdog_timeout && st.cfg[lpm_pkg::CFG_WATCHDOG_ENABLE]) begin
         reset_cause = 1'b1; // R11
      end
   end

   // wait wakes on any unmasked interrupt; stop only on external, keyboard, can or (with bus kept) timebase sources
   always_comb begin
      wake_ext_stop = (w.ext_irq && !st.cfg[lpm_pkg::CFG_EXT_IRQ_MASK]) // R14
         || (w.key_irq && !st.cfg[lpm_pkg::CFG_KEY_IRQ_MASK]) // R15
         || (w.tbm_irq && bus_keep) // R20
         || w.can_irq;
      wake_unmasked_wait = wake_ext_stop || w.adc_irq // R6
         || w.sci_irq || w.spi_irq || w.tim_irq // R17 R18 R19
         || w.tbm_irq || w.cgm_irq
         || (w.brk_irq && st.cfg[lpm_pkg::CFG_BREAK_ENABLE]);
   end

   always_comb begin
      next_st = st;
      // raw requests pass two flops before anything looks at them
      next_st.sync1 = wake_req; // R23
      next_st.sync2 = st.sync1; // R23
      next_st.reset_req = reset_cause;
      next_st.wd_prescaler_clr = 1'b0;
      next_st.rdata = 32'h0000_0000;
      if (ref_clock_tick) begin
         next_st.wd_div = !st.wd_div;
      end
      if (rd_access) begin
         unique case (paddr)
            lpm_pkg::ADDR_CFG: begin
               next_st.rdata = {22'h0, st.cfg};
            end
            lpm_pkg::ADDR_STATUS: begin
               next_st.rdata = {12'h000, st.recover_cnt,
                  4'h0, st.brk_flag, st.imask, st.mode};
            end
            default: begin
               next_st.rdata = 32'h0000_0000;
            end
         endcase
      end
      if (wr_access && paddr == lpm_pkg::ADDR_CFG
            && st.mode == lpm_pkg::LPM_RUN) begin
         next_st.cfg = pwdata[lpm_pkg::CFG_WIDTH-1:0];
      end
      unique case (st.mode)
         lpm_pkg::LPM_RUN: begin
            if (wait_instr || (wr_access && paddr == lpm_pkg::ADDR_CTRL
                  && pwdata[lpm_pkg::CTRL_ENTER_WAIT])) begin
               next_st.mode = lpm_pkg::LPM_WAIT;
               next_st.imask = 1'b0; // R3
            end else if ((stop_instr || (wr_access
                  && paddr == lpm_pkg::ADDR_CTRL
                  && pwdata[lpm_pkg::CTRL_ENTER_STOP])) && stop_allowed) begin
               next_st.mode = lpm_pkg::LPM_STOP; // R13
               next_st.imask = 1'b0; // R4
               next_st.wd_prescaler_clr = 1'b1; // R12
            end
         end
         lpm_pkg::LPM_WAIT: begin
            if (w.brk_irq && st.cfg[lpm_pkg::CFG_BREAK_ENABLE]) begin
               next_st.brk_flag = 1'b1; // R8
            end
            if (wake_unmasked_wait) begin
               next_st.mode = lpm_pkg::LPM_RUN; // R3
            end
         end
         lpm_pkg::LPM_STOP: begin
            if (wake_ext_stop) begin
               next_st.mode = lpm_pkg::LPM_RECOVER; // R5
               next_st.recover_cnt = st.cfg[lpm_pkg::CFG_SHORT_RECOVERY]
                  ? lpm_pkg::RECOVERY_SHORT : lpm_pkg::RECOVERY_LONG; // R22
            end
         end
         lpm_pkg::LPM_RECOVER: begin
            if (ref_clock_tick) begin
               if (st.recover_cnt == 12'h000) begin
                  next_st.mode = lpm_pkg::LPM_RUN; // R22
               end else begin
                  next_st.recover_cnt = st.recover_cnt - 12'h001; // R22
               end
            end
         end
      endcase
      // reset from any mode sets the mask and returns to run
      if (reset_cause) begin
         next_st.mode = lpm_pkg::LPM_RUN;
         next_st.imask = 1'b1; // R3 R4
         next_st.recover_cnt = 12'h000;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st <= '0;
         st.mode <= lpm_pkg::LPM_RUN;
         st.cfg <= lpm_pkg::CFG_RESET;
         st.imask <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign interrupt_mask_flag = st.imask;
   assign break_wait_flag = st.brk_flag;
   assign device_reset = st.reset_req;

   logic in_stop;
   logic in_wait;
   assign in_stop = st.mode == lpm_pkg::LPM_STOP
      || st.mode == lpm_pkg::LPM_RECOVER;
   assign in_wait = st.mode == lpm_pkg::LPM_WAIT;

   always_comb begin
      ctl.cpu_clk_en = st.mode == lpm_pkg::LPM_RUN; // R1 R2 R5
      ctl.bus_clk_en = !in_stop || (bus_keep
         && st.mode == lpm_pkg::LPM_STOP); // R2
      ctl.osc_en = !in_stop || osc_keep
         || st.mode == lpm_pkg::LPM_RECOVER; // R9 R10
      ctl.pll_en = !in_stop; // R10
      ctl.cgm_outputs_en = !(st.mode == lpm_pkg::LPM_STOP
         && !osc_keep); // R9
      ctl.watchdog_clock_en = !in_stop; // R12
      ctl.watchdog_prescaler_clr = st.wd_prescaler_clr; // R12
      ctl.adc_run = !in_stop; // R6 R7
      ctl.adc_abort = st.mode == lpm_pkg::LPM_STOP; // R7
      ctl.brk_active = !in_stop && st.cfg[lpm_pkg::CFG_BREAK_ENABLE]; // R8
      ctl.sci_run = !in_stop; // R17
      ctl.spi_run = !in_stop; // R18
      ctl.spi_reset = in_stop && reset_cause; // R18
      ctl.tim_run = !in_stop; // R19
      ctl.tbm_run = !in_stop || (bus_keep
         && st.mode == lpm_pkg::LPM_STOP); // R20
      ctl.tbm_cpu_access = st.mode == lpm_pkg::LPM_RUN; // R20
      ctl.can_run = !in_stop; // R21
      ctl.can_cpu_access = st.mode == lpm_pkg::LPM_RUN; // R21
      ctl.can_frame_abort = st.mode == lpm_pkg::LPM_STOP; // R21
   end

   assign osc_ref_clock_en = ctl.cgm_outputs_en; // R9
   assign main_clock_out_en = ctl.cgm_outputs_en; // R9
   assign clockgen_irq_out_en = ctl.cgm_outputs_en; // R9
   assign watchdog_clock = st.wd_div && ctl.watchdog_clock_en; // R12

   // clock gating per mode
   a_stop_gating: assert property (@(posedge clock) disable iff (rst) // R2
      st.mode == lpm_pkg::LPM_STOP |-> !ctl.cpu_clk_en
      && ctl.bus_clk_en == bus_keep)
      else $error("stop clock gating wrong");

   a_wait_clocks: assert property (@(posedge clock) disable iff (rst) // R1
      in_wait |-> !ctl.cpu_clk_en && ctl.bus_clk_en)
      else $error("wait clock gating wrong");

   a_stop_enable: assert property (@(posedge clock) disable iff (rst) // R13
      st.mode == lpm_pkg::LPM_RUN && !stop_allowed && !reset_cause
      && !wait_instr |=> st.mode != lpm_pkg::LPM_STOP)
      else $error("stop taken while disabled");

   a_mask_clear: assert property (@(posedge clock) disable iff (rst) // R3
      st.mode == lpm_pkg::LPM_RUN && $past(st.mode) == lpm_pkg::LPM_WAIT
      && !$past(reset_cause) |-> !st.imask)
      else $error("mask not clear after wait");

   a_reset_mask: assert property (@(posedge clock) disable iff (rst) // R4
      reset_cause |=> st.imask && st.mode == lpm_pkg::LPM_RUN)
      else $error("reset exit did not set mask");

   a_cgm_low: assert property (@(posedge clock) disable iff (rst) // R9
      st.mode == lpm_pkg::LPM_STOP && !osc_keep |-> !osc_ref_clock_en
      && !main_clock_out_en && !clockgen_irq_out_en)
      else $error("clock outputs not low");

   a_osc_kept: assert property (@(posedge clock) disable iff (rst) // R10
      st.mode == lpm_pkg::LPM_STOP && osc_keep |-> ctl.osc_en && !ctl.pll_en)
      else $error("oscillator not kept");

   a_wdog_cut: assert property (@(posedge clock) disable iff (rst) // R12
      in_stop |-> !watchdog_clock)
      else $error("watchdog clock in stop");

   a_recover_hold: assert property (@(posedge clock) disable iff (rst) // R5
      $rose(st.mode == lpm_pkg::LPM_RECOVER) && st.recover_cnt == 12'h01F
      |-> !ctl.cpu_clk_en [*8])
      else $error("cpu clock early");

   a_key_masked: assert property (@(posedge clock) disable iff (rst) // R15
      st.mode == lpm_pkg::LPM_STOP && !wake_ext_stop && !reset_cause
      |=> st.mode == lpm_pkg::LPM_STOP)
      else $error("stop left without wake");

   // mode entry and exit
   a_wait_entry: assert property (@(posedge clock) disable iff (rst) // R3
      st.mode == lpm_pkg::LPM_RUN && wait_instr && !reset_cause
      |=> st.mode == lpm_pkg::LPM_WAIT && !st.imask)
      else $error("wait entry wrong");

   a_stop_entry: assert property (@(posedge clock) disable iff (rst) // R4
      st.mode == lpm_pkg::LPM_RUN && stop_instr && stop_allowed
      && !wait_instr && !wr_access && !reset_cause
      |=> st.mode == lpm_pkg::LPM_STOP && !st.imask)
      else $error("stop entry wrong");

   a_wait_wake: assert property (@(posedge clock) disable iff (rst) // R3
      in_wait && wake_unmasked_wait && !reset_cause
      |=> st.mode == lpm_pkg::LPM_RUN && !st.imask)
      else $error("wait not left on wake");

   a_stop_wake: assert property (@(posedge clock) disable iff (rst) // R14
      st.mode == lpm_pkg::LPM_STOP && wake_ext_stop && !reset_cause
      |=> st.mode == lpm_pkg::LPM_RECOVER)
      else $error("stop not left on wake");

   a_ext_wake: assert property (@(posedge clock) disable iff (rst) // R14
      st.mode == lpm_pkg::LPM_STOP && w.ext_irq
      && !st.cfg[lpm_pkg::CFG_EXT_IRQ_MASK] |-> wake_ext_stop)
      else $error("external wake lost");

   a_key_wake: assert property (@(posedge clock) disable iff (rst) // R15
      st.mode == lpm_pkg::LPM_STOP && w.key_irq
      && !st.cfg[lpm_pkg::CFG_KEY_IRQ_MASK] |-> wake_ext_stop)
      else $error("keyboard wake lost");

   a_adc_wake: assert property (@(posedge clock) disable iff (rst) // R6
      in_wait && w.adc_irq && !reset_cause |=> st.mode == lpm_pkg::LPM_RUN)
      else $error("converter wake lost");

   a_adc_stop: assert property (@(posedge clock) disable iff (rst) // R7
      st.mode == lpm_pkg::LPM_STOP |-> ctl.adc_abort && !ctl.adc_run)
      else $error("converter not aborted");

   // break, watchdog and voltage monitor
   a_brk_flag: assert property (@(posedge clock) disable iff (rst) // R8
      in_wait && w.brk_irq && st.cfg[lpm_pkg::CFG_BREAK_ENABLE]
      |=> st.brk_flag)
      else $error("break flag not set");

   a_brk_keep: assert property (@(posedge clock) disable iff (rst) // R8
      in_stop |=> $stable(st.brk_flag) && !ctl.brk_active)
      else $error("break state changed in stop");

   a_wdog_reset: assert property (@(posedge clock) disable iff (rst) // R11
      (st.mode == lpm_pkg::LPM_RUN || in_wait) && w.wdog_timeout
      && st.cfg[lpm_pkg::CFG_WATCHDOG_ENABLE] |=> device_reset)
      else $error("watchdog reset lost");

   a_lvi_reset: assert property (@(posedge clock) disable iff (rst) // R16
      w.lvi_trip && st.cfg[lpm_pkg::CFG_LVI_ENABLE]
      && st.cfg[lpm_pkg::CFG_LVI_RESET_ENABLE] |=> device_reset)
      else $error("voltage reset lost");

   a_prescale_clr: assert property (@(posedge clock) disable iff (rst) // R12
      $rose(st.mode == lpm_pkg::LPM_STOP) |-> ctl.watchdog_prescaler_clr)
      else $error("prescaler not cleared");

   // peripherals frozen in stop (timebase runs when bus kept), can in wait
   a_sci_halt: assert property (@(posedge clock) disable iff (rst) // R17
      in_stop |-> !ctl.sci_run)
      else $error("serial port runs in stop");

   a_spi_halt: assert property (@(posedge clock) disable iff (rst) // R18
      in_stop |-> !ctl.spi_run && (ctl.spi_reset == reset_cause))
      else $error("spi stop handling wrong");

   a_tim_halt: assert property (@(posedge clock) disable iff (rst) // R19
      in_stop |-> !ctl.tim_run)
      else $error("timers run in stop");

   a_tbm_stop: assert property (@(posedge clock) disable iff (rst) // R20
      st.mode == lpm_pkg::LPM_STOP |-> ctl.tbm_run == bus_keep
      && !ctl.tbm_cpu_access)
      else $error("timebase stop handling wrong");

   a_can_wait: assert property (@(posedge clock) disable iff (rst) // R21
      in_wait |-> ctl.can_run && !ctl.can_cpu_access)
      else $error("can wait handling wrong");

   a_can_stop: assert property (@(posedge clock) disable iff (rst) // R21
      st.mode == lpm_pkg::LPM_STOP |-> !ctl.can_run && ctl.can_frame_abort)
      else $error("can stop handling wrong");

   // recovery counter
   a_load_short: assert property (@(posedge clock) disable iff (rst) // R22
      st.mode == lpm_pkg::LPM_STOP && wake_ext_stop && !reset_cause
      && st.cfg[lpm_pkg::CFG_SHORT_RECOVERY]
      |=> st.recover_cnt == lpm_pkg::RECOVERY_SHORT)
      else $error("short recovery not loaded");

   a_load_long: assert property (@(posedge clock) disable iff (rst) // R22
      st.mode == lpm_pkg::LPM_STOP && wake_ext_stop && !reset_cause
      && !st.cfg[lpm_pkg::CFG_SHORT_RECOVERY]
      |=> st.recover_cnt == lpm_pkg::RECOVERY_LONG)
      else $error("long recovery not loaded");

   a_recover_step: assert property (@(posedge clock) disable iff (rst) // R22
      st.mode == lpm_pkg::LPM_RECOVER && ref_clock_tick && !reset_cause
      && st.recover_cnt != 12'h000
      |=> st.recover_cnt == $past(st.recover_cnt) - 12'h001)
      else $error("recovery count step wrong");

   a_recover_cpu: assert property (@(posedge clock) disable iff (rst) // R5
      st.mode == lpm_pkg::LPM_RECOVER |-> !ctl.cpu_clk_en && !ctl.bus_clk_en)
      else $error("clocks run in recovery");

   // configuration only changes in run
   a_cfg_frozen: assert property (@(posedge clock) disable iff (rst) // R13
      st.mode != lpm_pkg::LPM_RUN |=> $stable(st.cfg))
      else $error("configuration changed outside run");
endmodule : lpm_ctrl

// ### src/lpm_pkg.sv
// package for the low-power mode controller: map, fields, types, counts
package lpm_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   // configuration register field positions
   localparam int CFG_STOP_ENABLE = 0;
   localparam int CFG_STOP_OSC_ENABLE = 1;
   localparam int CFG_OSC_RUN_IN_STOP = 2;
   localparam int CFG_SHORT_RECOVERY = 3;
   localparam int CFG_EXT_IRQ_MASK = 4;
   localparam int CFG_KEY_IRQ_MASK = 5;
   localparam int CFG_LVI_ENABLE = 6;
   localparam int CFG_LVI_RESET_ENABLE = 7;
   localparam int CFG_WATCHDOG_ENABLE = 8;
   localparam int CFG_BREAK_ENABLE = 9;
   localparam int CFG_WIDTH = 10;
   localparam logic [9:0] CFG_RESET = 10'h0C0;
   // control register (write-only strobes)
   localparam int CTRL_ENTER_WAIT = 0;
   localparam int CTRL_ENTER_STOP = 1;
   // recovery counts in reference-clock cycles
   localparam logic [11:0] RECOVERY_LONG = 12'hFFF;
   localparam logic [11:0] RECOVERY_SHORT = 12'h01F;

   typedef enum logic [1:0] {
      LPM_RUN = 2'b00,
      LPM_WAIT = 2'b01,
      LPM_STOP = 2'b10,
      LPM_RECOVER = 2'b11
   } lpm_mode_e;

   // wake and reset sources from peripherals
   typedef struct packed {
      logic ext_irq;
      logic key_irq;
      logic adc_irq;
      logic sci_irq;
      logic spi_irq;
      logic tim_irq;
      logic tbm_irq;
      logic can_irq;
      logic cgm_irq;
      logic brk_irq;
      logic wdog_timeout;
      logic lvi_trip;
   } lpm_wake_s;

   // per-peripheral run / freeze / abort controls
   typedef struct packed {
      logic cpu_clk_en;
      logic bus_clk_en;
      logic osc_en;
      logic pll_en;
      logic cgm_outputs_en;
      logic watchdog_clock_en;
      logic watchdog_prescaler_clr;
      logic adc_run;
      logic adc_abort;
      logic brk_active;
      logic sci_run;
      logic spi_run;
      logic spi_reset;
      logic tim_run;
      logic tbm_run;
      logic tbm_cpu_access;
      logic can_run;
      logic can_cpu_access;
      logic can_frame_abort;
   } lpm_ctl_s;
endpackage : lpm_pkg

// ### tb/lpm_ctrl_test.sv
// self-checking bench for the low-power mode controller
`timescale 1ns/10ps
module lpm_ctrl_test;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, ref_clock_tick, e;
   logic wait_instr = 1'b0;
   logic stop_instr = 1'b0;
   lpm_pkg::lpm_wake_s wake_cmd = '0;
   lpm_pkg::lpm_wake_s wake_req;
   lpm_pkg::lpm_ctl_s ctl;
   logic imask, brk_flag, dev_rst, xclk_en, out_en, cgi_en, wd_clk;
   logic [31:0] q;
   int n;
   int err_total = 0;
   int comparisons = 0;
   int clr_count = 0;

   always #25 clock = ~clock;

   lpm_ctrl dut_u (.clock(clock), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wait_instr(wait_instr), .stop_instr(stop_instr),
      .ref_clock_tick(ref_clock_tick), .wake_req(wake_req),
      .interrupt_mask_flag(imask), .break_wait_flag(brk_flag),
      .device_reset(dev_rst), .ctl(ctl), .osc_ref_clock_en(xclk_en),
      .main_clock_out_en(out_en), .clockgen_irq_out_en(cgi_en),
      .watchdog_clock(wd_clk));

   lpm_periph_model model_u (.clock(clock), .rst(rst), .wake_cmd(wake_cmd),
      .cpu_clk_en(ctl.cpu_clk_en), .ref_clock_tick(ref_clock_tick),
      .wake_req(wake_req));

   // the prescaler clear stands one cycle only, so it is counted here
   always @(posedge clock) begin
      if (ctl.watchdog_prescaler_clr === 1'b1) clr_count++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      if (err_total == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict

   // entered just after a rising edge; returns just after the edge that follows the pready edge
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb

   task automatic instr(input logic stop);
      // let a wake still in the synchroniser drain before the next mode
      repeat (4) @(posedge clock);
      wait_instr <= ~stop;
      stop_instr <= stop;
      @(posedge clock);
      wait_instr <= 1'b0;
      stop_instr <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : instr

   task automatic wake(input lpm_pkg::lpm_wake_s w);
      wake_cmd <= w;
      @(posedge clock);
      wake_cmd <= '0;
   endtask : wake

   // counts reference ticks seen while the cpu clock is still held off
   task automatic recover;
      n = 0;
      for (int i = 0; i < 20000 && ctl.cpu_clk_en !== 1'b1; i++) begin
         @(posedge clock);
         if (ref_clock_tick === 1'b1 && ctl.cpu_clk_en !== 1'b1) n++;
      end
   endtask : recover

   task automatic t_reset;
      apb(1'b0, lpm_pkg::ADDR_CFG, 32'h0);
      check(q, 32'h000000C0);
      apb(1'b0, lpm_pkg::ADDR_STATUS, 32'h0);
      check(q[2:0], 3'h4);
      apb(1'b0, 8'h0C, 32'h0);
      check(e, 1'b1);
      check(q, 32'h0);
      instr(1'b1);
      check(ctl.cpu_clk_en, 1'b1);
      apb(1'b0, lpm_pkg::ADDR_STATUS, 32'h0);
      check(q[1:0], 2'h0);
   endtask : t_reset

   task automatic t_wait;
      apb(1'b1, lpm_pkg::ADDR_CFG, 32'h000002C0);
      instr(1'b0);
      check({ctl.cpu_clk_en, ctl.bus_clk_en}, 2'b01);
      check(imask, 1'b0);
      check({ctl.adc_run, ctl.sci_run, ctl.spi_run, ctl.tim_run,
         ctl.tbm_run, ctl.can_run, ctl.brk_active}, 7'h7F);
      check({ctl.tbm_cpu_access, ctl.can_cpu_access}, 2'b00);
      check(ctl.watchdog_clock_en, 1'b1);
      wake(lpm_pkg::lpm_wake_s'(12'h800));
      recover;
      // every source from break up to external interrupt must end wait
      for (int b = 2; b < 12; b++) begin
         instr(1'b0);
         wake(lpm_pkg::lpm_wake_s'(12'h001 << b));
         recover;
         check(ctl.cpu_clk_en, 1'b1);
         check(imask, 1'b0);
      end
      check(brk_flag, 1'b1);
   endtask : t_wait

   task automatic t_stop(input logic [31:0] cfg, input logic [3:0] clk,
      input lpm_pkg::lpm_wake_s w, input int lo);
      int c0;
      apb(1'b1, lpm_pkg::ADDR_CFG, cfg);
      c0 = clr_count;
      instr(1'b1);
      check({ctl.cpu_clk_en, ctl.bus_clk_en, ctl.osc_en, ctl.pll_en},
         clk);
      if (cfg[2] == 1'b0) check({xclk_en, out_en, cgi_en,
         ctl.cgm_outputs_en}, 4'h0);
      check(ctl.watchdog_clock_en, 1'b0);
      check(clr_count - c0, 1);
      check({ctl.adc_abort, ctl.can_frame_abort, wd_clk}, 3'b110);
      check({ctl.adc_run, ctl.sci_run, ctl.spi_run, ctl.tim_run,
         ctl.can_run, ctl.brk_active}, 6'h00);
      check(ctl.tbm_run, cfg[1]);
      check(imask, 1'b0);
      wake(lpm_pkg::lpm_wake_s'(12'h400));
      repeat (8) @(posedge clock);
      check(ctl.cpu_clk_en, 1'b0);
      wake(w);
      recover;
      check(n >= lo && n <= lo + 1, 1'b1);
      check(imask, 1'b0);
   endtask : t_stop

   // a reset cause ends the mode; the external reset then sets the mask
   task automatic t_rst_exit(input logic [31:0] cfg, input logic stop,
      input lpm_pkg::lpm_wake_s w);
      apb(1'b1, lpm_pkg::ADDR_CFG, cfg);
      instr(stop);
      wake(w);
      repeat (6) @(posedge clock);
      check(dev_rst, 1'b1);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      check(imask, 1'b1);
   endtask : t_rst_exit

   initial begin
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_reset;
      t_wait;
      t_stop(32'h000000E9, 4'h0, lpm_pkg::lpm_wake_s'(12'h800), 32);
      t_stop(32'h000000E7, 4'h6, lpm_pkg::lpm_wake_s'(12'h020), 4096);
      t_rst_exit(32'h000001C0, 1'b0, lpm_pkg::lpm_wake_s'(12'h002));
      t_rst_exit(32'h000000C0, 1'b0, lpm_pkg::lpm_wake_s'(12'h001));
      t_rst_exit(32'h000000C1, 1'b1, lpm_pkg::lpm_wake_s'(12'h001));
      give_verdict;
   end

   // the long recovery alone takes about 16k cycles
   initial begin
      repeat (60000) @(posedge clock);
      err_total++;
      give_verdict;
   end
endmodule : lpm_ctrl_test

// ### tb/lpm_periph_model.sv
// stand-in for the cpu and peripherals: reference ticks and wake levels
`timescale 1ns/10ps
module lpm_periph_model (
   input wire logic clock,
   input wire logic rst,
   input wire lpm_pkg::lpm_wake_s wake_cmd,
   input wire logic cpu_clk_en,
   output logic ref_clock_tick,
   output lpm_pkg::lpm_wake_s wake_req
);
   logic [1:0] div;
   assign ref_clock_tick = (div == 2'h3);
   // a request is held like a pending latch until the cpu clock returns
   always_ff @(posedge clock) begin
      if (rst) begin
         div <= 2'h0;
         wake_req <= '0;
      end else begin
         div <= div + 2'h1;
         wake_req <= lpm_pkg::lpm_wake_s'((wake_req | wake_cmd)
            & {12{~cpu_clk_en}});
      end
   end
endmodule : lpm_periph_model
